//--- core/mml_map.vh
// Address map, field positions, reset values and opcode patterns for mml_exec.
// Included by mml_exec, its monitor and the bench; the guard protects against double inclusion.
`ifndef MML_MAP_VH
`define MML_MAP_VH

// ==========================================================
// Register byte offsets (haddr[11:0])
`define MML_OFS_INSTR    12'h000
`define MML_OFS_FLAGS    12'h004
`define MML_OFS_ACC      12'h008
`define MML_OFS_BANK     12'h00c
`define MML_OFS_PC       12'h010
`define MML_OFS_LATCH    12'h014
`define MML_OFS_PROD     12'h018
`define MML_OFS_STACK    12'h01c
`define MML_OFS_INDPTR   12'h020
`define MML_OFS_CONFIG   12'h024
// Data memory window: 0x400 + 4*location
`define MML_WIN_SEL      2'h1

// ==========================================================
// Field positions
`define MML_FLG_C        0
`define MML_FLG_DC       1
`define MML_FLG_Z        2
`define MML_FLG_OV       3
`define MML_CFG_REDUCED  0
`define MML_CFG_BUSY     8

// ==========================================================
// Reset values
`define MML_RST_BYTE     8'h00
`define MML_RST_WORD     16'h0000
`define MML_RST_FLAGS    4'h0
`define MML_RST_SP       4'h0

// ==========================================================
// Special data locations
`define MML_ADDR_IND     8'h00
`define MML_ADDR_ACC     8'h0a

// ==========================================================
// Opcode patterns
`define MML_OP_OR        7'h04
`define MML_OP_FAR       8'hb7
`define MML_OP_F2P       3'h3
`define MML_OP_P2F       3'h2
`define MML_OP_BLO       8'hb8
`define MML_OP_BHI       7'h5d
`define MML_OP_LDI       8'hb0
`define MML_OP_STO       8'h01
`define MML_OP_MULI      8'hbc
`define MML_OP_MULF      8'h34
`define MML_OP_NEG       7'h16

`endif

//--- core/mml_exec.v
// Executor for one instruction group of an 8-bit core, reached over AHB-Lite.
// Assumes one AHB-Lite master on core_clk; single word transfers only.
// Data memory and stack contents are not reset; read only what was written.

`include "mml_map.vh"

module mml_exec (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Execution state
	output wire        exec_busy
);

	// ==========================================================
	// Sequencer states: idle, then one per quarter-cycle
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_Q1   = 5'b00010;
	localparam [4:0] ST_Q2   = 5'b00100;
	localparam [4:0] ST_Q3   = 5'b01000;
	localparam [4:0] ST_Q4   = 5'b10000;

	reg [4:0]  st_q;
	reg        nop_q;
	reg [15:0] ir_q;
	reg [7:0]  acc_q;
	reg [3:0]  flags_q;
	reg [7:0]  bank_q;
	reg [15:0] pc_q;
	reg [7:0]  latch_q;
	reg [7:0]  prod_hi_q;
	reg [7:0]  prod_lo_q;
	reg [7:0]  ind_ptr_q;
	reg        reduced_q;
	reg [3:0]  sp_q;
	reg [7:0]  opnd_q;
	reg [7:0]  res_q;
	reg        res_c_q;
	reg        res_dc_q;
	reg        res_ov_q;
	reg        dp_wr_q;
	reg [11:0] dp_addr_q;
	reg [31:0] hrdata_q;
	reg        hready_q;
	reg        busy_q;
	reg        hresp_q;

	reg [7:0]  mem [0:255];
	reg [15:0] stack_mem [0:15];

	assign hrdata    = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp     = hresp_q;
	assign exec_busy = busy_q;

	// ==========================================================
	// Decode
	wire op_or   = (ir_q[15:9] == `MML_OP_OR);
	wire op_far  = (ir_q[15:8] == `MML_OP_FAR);
	wire op_f2p  = (ir_q[15:13] == `MML_OP_F2P);
	wire op_p2f  = (ir_q[15:13] == `MML_OP_P2F);
	wire op_blo  = (ir_q[15:8] == `MML_OP_BLO);
	wire op_bhi  = (ir_q[15:9] == `MML_OP_BHI) & ~reduced_q;
	wire op_ldi  = (ir_q[15:8] == `MML_OP_LDI);
	wire op_sto  = (ir_q[15:8] == `MML_OP_STO);
	wire op_muli = (ir_q[15:8] == `MML_OP_MULI) & ~reduced_q;
	wire op_mulf = (ir_q[15:8] == `MML_OP_MULF) & ~reduced_q;
	wire op_neg  = (ir_q[15:9] == `MML_OP_NEG);
	wire bit_d   = ir_q[8];

	// Operand addresses, location zero redirects through the pointer
	wire [7:0] f_raw  = ir_q[7:0];
	wire [7:0] p_raw  = {3'b000, ir_q[12:8]};
	wire [7:0] f_addr = (f_raw == `MML_ADDR_IND) ? ind_ptr_q : f_raw;
	wire [7:0] p_addr = (p_raw == `MML_ADDR_IND) ? ind_ptr_q : p_raw;
	wire [7:0] src_addr = op_p2f ? p_addr : f_addr;
	wire [7:0] dst_addr = op_f2p ? p_addr : f_addr;
	wire [7:0] src_val  = (src_addr == `MML_ADDR_ACC) ? acc_q : mem[src_addr];
	wire       imm_src  = op_ldi | op_muli | op_far;

	// ==========================================================
	// Arithmetic
	wire [8:0]  neg_sum = {1'b0, ~acc_q} + 9'h001;
	wire [4:0]  neg_lo  = {1'b0, ~acc_q[3:0]} + 5'h01;
	wire [15:0] acc_wide  = {8'h00, acc_q};
	wire [15:0] opnd_wide = {8'h00, opnd_q};
	wire [15:0] prod      = acc_wide * opnd_wide;
	wire [15:0] pc_inc  = pc_q + 16'h0001;
	wire [3:0]  sp_top  = sp_q - 4'h1;
	wire [15:0] stack_top = stack_mem[sp_top];
	wire [7:0]  bank_rd = reduced_q ? {4'h0, bank_q[3:0]} : bank_q;

	// ==========================================================
	// Quarter-four write strobes
	wire q4_live = (st_q == ST_Q4) & ~nop_q;
	wire wr_dst  = q4_live & ((op_or & bit_d) | op_f2p | op_p2f | op_sto | op_neg);
	wire wr_acc  = q4_live & ((op_or & ~bit_d) | op_ldi | (op_neg & ~bit_d));
	wire push    = q4_live & op_far;

	// ==========================================================
	// Bus decode
	// Size is not decoded: every transfer is taken as one full word
	wire        ap_take = hsel & htrans[1] & hready;
	wire        idle    = (st_q == ST_IDLE);
	wire        bw_ok   = dp_wr_q & idle;
	wire        bw_win  = bw_ok & (dp_addr_q[11:10] == `MML_WIN_SEL);
	wire        bw_reg  = bw_ok & (dp_addr_q[11:10] == 2'h0);

	// Execution writes own the port; window writes land only while idle
	reg        mem_we;
	reg [7:0]  mem_wa;
	reg [7:0]  mem_wd;
	always @* begin
		mem_we = 1'b0;
		mem_wa = dst_addr;
		mem_wd = res_q;
		if (wr_dst && dst_addr != `MML_ADDR_ACC) begin
			mem_we = 1'b1;
		end else if (bw_win) begin
			mem_we = 1'b1;
			mem_wa = dp_addr_q[9:2];
			mem_wd = hwdata[7:0];
		end
	end

	// Status word, bits at their mapped positions
	reg [31:0] cfg_word;
	always @* begin
		cfg_word = 32'h0000_0000;
		cfg_word[`MML_CFG_REDUCED] = reduced_q;
		cfg_word[`MML_CFG_BUSY]    = busy_q;
	end

	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h0000_0000;
		if (haddr[11:10] == `MML_WIN_SEL) begin
			rd_val = {24'h00_0000, mem[haddr[9:2]]};
		end else if (haddr[11:10] == 2'h0) begin
			case (haddr[11:0])
				`MML_OFS_INSTR:  rd_val = {16'h0000, ir_q};
				`MML_OFS_FLAGS:  rd_val = {28'h000_0000, flags_q};
				`MML_OFS_ACC:    rd_val = {24'h00_0000, acc_q};
				`MML_OFS_BANK:   rd_val = {24'h00_0000, bank_rd};
				`MML_OFS_PC:     rd_val = {16'h0000, pc_q};
				`MML_OFS_LATCH:  rd_val = {24'h00_0000, latch_q};
				`MML_OFS_PROD:   rd_val = {16'h0000, prod_hi_q, prod_lo_q};
				`MML_OFS_STACK:  rd_val = {16'h0000, stack_top};
				`MML_OFS_INDPTR: rd_val = {24'h00_0000, ind_ptr_q};
				`MML_OFS_CONFIG: rd_val = cfg_word;
				default:         rd_val = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Arrays, no reset
	always @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		// Sixteen entries; the pointer wraps on overflow
		if (push) begin
			stack_mem[sp_q] <= pc_inc;
		end
	end

	// ==========================================================
	// Bus slave
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 12'h000;
			hrdata_q  <= 32'h0000_0000;
			hready_q  <= 1'b0;
			hresp_q   <= 1'b0;
		end else begin
			hready_q <= 1'b1;
			hresp_q  <= 1'b0;
			dp_wr_q  <= ap_take & hwrite;
			if (ap_take) begin
				dp_addr_q <= haddr[11:0];
			end
			// Read data is taken in the address phase, ahead of a write still in its data phase
			if (ap_take && !hwrite) begin
				hrdata_q <= rd_val;
			end
		end
	end

	// ==========================================================
	// Sequencer and architectural state
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q      <= ST_IDLE;
			nop_q     <= 1'b0;
			busy_q    <= 1'b0;
			ir_q      <= `MML_RST_WORD;
			acc_q     <= `MML_RST_BYTE;
			flags_q   <= `MML_RST_FLAGS;
			bank_q    <= `MML_RST_BYTE;
			pc_q      <= `MML_RST_WORD;
			latch_q   <= `MML_RST_BYTE;
			prod_hi_q <= `MML_RST_BYTE;
			prod_lo_q <= `MML_RST_BYTE;
			ind_ptr_q <= `MML_RST_BYTE;
			reduced_q <= 1'b0;
			sp_q      <= `MML_RST_SP;
			opnd_q    <= `MML_RST_BYTE;
			res_q     <= `MML_RST_BYTE;
			res_c_q   <= 1'b0;
			res_dc_q  <= 1'b0;
			res_ov_q  <= 1'b0;
		end else begin
			// Register writes land only while no instruction runs
			if (bw_reg) begin
				case (dp_addr_q)
					`MML_OFS_INSTR: begin
						ir_q   <= hwdata[15:0];
						st_q   <= ST_Q1;
						busy_q <= 1'b1;
					end
					`MML_OFS_FLAGS:  flags_q <= hwdata[3:0];
					`MML_OFS_ACC:    acc_q <= hwdata[7:0];
					`MML_OFS_BANK:   bank_q <= reduced_q ? {4'h0, hwdata[3:0]} : hwdata[7:0];
					`MML_OFS_PC:     pc_q <= hwdata[15:0];
					`MML_OFS_LATCH:  latch_q <= hwdata[7:0];
					`MML_OFS_PROD: begin
						prod_hi_q <= hwdata[15:8];
						prod_lo_q <= hwdata[7:0];
					end
					`MML_OFS_INDPTR: ind_ptr_q <= hwdata[7:0];
					`MML_OFS_CONFIG: reduced_q <= hwdata[`MML_CFG_REDUCED];
					default: begin
					end
				endcase
			end
			case (st_q)
				ST_IDLE: begin
				end
				ST_Q1: begin
					st_q <= ST_Q2;
				end
				ST_Q2: begin
					st_q <= ST_Q3;
					if (!nop_q) begin
						opnd_q <= imm_src ? ir_q[7:0] : src_val;
					end
				end
				ST_Q3: begin
					st_q <= ST_Q4;
					// Negating 8'h80 is the only signed wrap
					res_c_q  <= neg_sum[8];
					res_dc_q <= neg_lo[4];
					res_ov_q <= neg_sum[7] & acc_q[7];
					if (op_or) begin
						res_q <= acc_q | opnd_q;
					end else if (op_sto) begin
						res_q <= acc_q;
					end else if (op_neg) begin
						res_q <= neg_sum[7:0];
					end else begin
						res_q <= opnd_q;
					end
				end
				ST_Q4: begin
					if (nop_q) begin
						nop_q  <= 1'b0;
						st_q   <= ST_IDLE;
						busy_q <= 1'b0;
					end else if (op_far) begin
						// Second pass runs as the forced no-op
						pc_q  <= {latch_q, ir_q[7:0]};
						sp_q  <= sp_q + 4'h1;
						nop_q <= 1'b1;
						st_q  <= ST_Q1;
					end else begin
						pc_q   <= pc_inc;
						st_q   <= ST_IDLE;
						busy_q <= 1'b0;
					end
					if (wr_acc || (wr_dst && dst_addr == `MML_ADDR_ACC)) begin
						acc_q <= res_q;
					end
					if (op_blo && !nop_q) begin
						bank_q[3:0] <= ir_q[3:0];
					end
					if (op_bhi && !nop_q) begin
						bank_q[7:4] <= ir_q[7:4];
					end
					if ((op_muli || op_mulf) && !nop_q) begin
						prod_hi_q <= prod[15:8];
						prod_lo_q <= prod[7:0];
					end
					if ((op_or || op_p2f || op_neg) && !nop_q) begin
						flags_q[`MML_FLG_Z] <= (res_q == 8'h00);
					end
					if (op_neg && !nop_q) begin
						flags_q[`MML_FLG_C]  <= res_c_q;
						flags_q[`MML_FLG_DC] <= res_dc_q;
						flags_q[`MML_FLG_OV] <= res_ov_q;
					end
				end
				default: begin
					st_q   <= ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

endmodule // mml_exec

//--- sim/mml_exec_monitor.sv
// Checker for the mml_exec bus answers and execution span.
// Assumes a bind onto mml_exec; sees its ports only.
`include "mml_map.vh"
module mml_exec_monitor (
	// Clock and reset
	input logic        core_clk,
	input logic        rst_b,
	// Bus and status
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic [31:0] hrdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic        exec_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Tracks the instruction word that starts each execution
	logic        tk;
	logic        go;
	logic        wp_q;
	logic        go_q;
	logic        far_q;
	logic [11:0] wa_q;
	assign tk = hsel & htrans[1] & hready;
	assign go = wp_q & hready & (wa_q == `MML_OFS_INSTR) & !exec_busy;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q  <= 1'b0;
			wa_q  <= 12'h000;
			go_q  <= 1'b0;
			far_q <= 1'b0;
		end else begin
			if (hready) begin
				wp_q <= tk & hwrite;
				wa_q <= haddr[11:0];
			end
			go_q <= go;
			if (go)
				far_q <= (hwdata[15:8] == `MML_OP_FAR);
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_ready_high: assert property ($past(rst_b) |-> hreadyout) else $error("ready low after reset");
	a_busy_start: assert property ((tk & hwrite & !exec_busy & (haddr[11:0] == `MML_OFS_INSTR)) |=> ##1 exec_busy)
		else $error("instruction write did not start execution");
	a_busy_cause: assert property ($rose(exec_busy) |-> go_q) else $error("execution started without a write");
	a_far_span: assert property ($rose(exec_busy) && far_q |-> exec_busy[*8] ##1 !exec_busy)
		else $error("far call span wrong");
	a_single_span: assert property ($rose(exec_busy) && !far_q |-> exec_busy[*4] ##1 !exec_busy)
		else $error("single cycle span wrong");
	a_unmapped_zero: assert property ((tk & !hwrite & haddr[11:0] >= 12'h028 & haddr[11:0] < 12'h400)
		|=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
	a_config_busy: assert property ((tk & !hwrite & (haddr[11:0] == `MML_OFS_CONFIG))
		|=> hrdata[8] == $past(exec_busy) && hrdata[31:9] == 23'h00_0000) else $error("busy bit readback wrong");
	c_far: cover property ($rose(exec_busy) && far_q);
	c_unmapped: cover property (tk & !hwrite & (haddr[11:0] == 12'h100));
	c_poll: cover property (tk & !hwrite & exec_busy);
endmodule // mml_exec_monitor

//--- sim/tb_mcu_move_logic_mul_instr.sv
// Self-checking bench for mml_exec: moves, multiply, bank loads, call, negate.
// Assumes mml_exec and its map header; the bench is the only AHB-Lite master.
`include "mml_map.vh"
module tb_mcu_move_logic_mul_instr;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] IR = `MML_OFS_INSTR, FL = `MML_OFS_FLAGS, AC = `MML_OFS_ACC, BK = `MML_OFS_BANK;
	localparam logic [11:0] PCR = `MML_OFS_PC, LA = `MML_OFS_LATCH, PR = `MML_OFS_PROD, ST = `MML_OFS_STACK;
	localparam logic [11:0] IP = `MML_OFS_INDPTR, CF = `MML_OFS_CONFIG;
	// Clock, reset and bus
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        exec_busy;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	always #25 core_clk = ~core_clk;
	mml_exec dut_u (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.exec_busy(exec_busy));
	// ==========
	// Bus tasks
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdv);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] x;
		bus(1'b1, a, {16'h0000, d}, x);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(x, {16'h0000, e});
	endtask
	task automatic idle();
		logic [31:0] x;
		x = 32'h0000_0100;
		while (x[8] !== 1'b0)
			bus(1'b0, CF, 32'h0000_0000, x);
	endtask
	task automatic run(input logic [15:0] op);
		wr(IR, op);
		idle();
	endtask
	function automatic logic [11:0] m(input logic [7:0] n);
		return {`MML_WIN_SEL, n, 2'h0};
	endfunction
	// ==========
	// Scenarios
	task automatic t_or();
		wr(FL, 16'h000b);
		wr(AC, 16'h0091);
		wr(m(8'h20), 16'h0013);
		run(16'h0820);
		rd(AC, 16'h0093);
		rd(m(8'h20), 16'h0013);
		wr(AC, 16'h0040);
		run(16'h0920);
		rd(m(8'h20), 16'h0053);
		rd(AC, 16'h0040);
		rd(FL, 16'h000b);
		wr(AC, 16'h0000);
		wr(m(8'h21), 16'h0000);
		run(16'h0821);
		rd(FL, 16'h000f);
	endtask
	task automatic t_far();
		wr(LA, 16'h0012);
		wr(PCR, 16'h0040);
		run(16'hb734);
		rd(PCR, 16'h1234);
		rd(ST, 16'h0041);
		wr(ST, 16'h0099);
		rd(ST, 16'h0041);
	endtask
	task automatic t_mov();
		wr(FL, 16'h000f);
		wr(m(8'h30), 16'h005a);
		run(16'h6330);
		rd(m(8'h03), 16'h005a);
		rd(FL, 16'h000f);
		run(16'h4331);
		rd(m(8'h31), 16'h005a);
		rd(FL, 16'h000b);
		wr(m(8'h04), 16'h0000);
		run(16'h4432);
		rd(FL, 16'h000f);
		wr(AC, 16'h0077);
		run(16'h650a);
		rd(m(8'h05), 16'h0077);
		wr(IP, 16'h0040);
		wr(m(8'h40), 16'h003c);
		run(16'h6600);
		rd(m(8'h06), 16'h003c);
		run(16'h430a);
		rd(AC, 16'h005a);
		run(16'h6031);
		rd(m(8'h40), 16'h005a);
	endtask
	task automatic t_mul();
		wr(FL, 16'h000b);
		wr(AC, 16'h0000);
		run(16'hbc37);
		rd(FL, 16'h000b);
		wr(AC, 16'h00e2);
		run(16'hbcc4);
		rd(PR, 16'had08);
		rd(AC, 16'h00e2);
		wr(AC, 16'h00c4);
		wr(m(8'h50), 16'h00b5);
		run(16'h3450);
		rd(PR, 16'h8a94);
		rd(m(8'h50), 16'h00b5);
		rd(FL, 16'h000b);
	endtask
	task automatic t_bank();
		wr(BK, 16'h0022);
		run(16'hb805);
		rd(BK, 16'h0025);
		run(16'hb8a3);
		rd(BK, 16'h0023);
		run(16'hba50);
		rd(BK, 16'h0053);
		run(16'hbb7f);
		rd(BK, 16'h0073);
		wr(CF, 16'h0001);
		rd(BK, 16'h0003);
		run(16'hba90);
		run(16'hbcff);
		rd(BK, 16'h0003);
		rd(PR, 16'h8a94);
		wr(CF, 16'h0000);
	endtask
	task automatic t_ldst();
		wr(FL, 16'h000b);
		run(16'hb05a);
		rd(AC, 16'h005a);
		run(16'h01ff);
		rd(m(8'hff), 16'h005a);
		run(16'hb000);
		run(16'h01fe);
		rd(m(8'hfe), 16'h0000);
		rd(FL, 16'h000b);
	endtask
	// Flags start inverted so every flag must be written
	task automatic t_neg(input logic [15:0] a, input logic [15:0] op, input logic [15:0] ea, input logic [15:0] ef);
		wr(FL, ~ef & 16'h000f);
		wr(AC, a);
		wr(m(op[7:0]), 16'h00ee);
		run(op);
		rd(AC, ea);
		rd(m(op[7:0]), (16'h0000 - a) & 16'h00ff);
		rd(FL, ef);
	endtask
	// Write while busy is dropped; unmapped read is zero
	task automatic t_misc();
		rd(12'h100, 16'h0000);
		wr(IR, 16'hb066);
		wr(AC, 16'h0011);
		idle();
		rd(AC, 16'h0066);
	endtask
	task automatic give_verdict();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		t_or();
		t_far();
		t_mov();
		t_mul();
		t_bank();
		t_ldst();
		t_neg(16'h003a, 16'h2c20, 16'h00c6, 16'h0000);
		t_neg(16'h0080, 16'h2d21, 16'h0080, 16'h000a);
		t_neg(16'h0000, 16'h2c22, 16'h0000, 16'h0007);
		t_neg(16'h0001, 16'h2d23, 16'h0001, 16'h0000);
		t_misc();
		give_verdict();
	end
	initial begin
		repeat (8000) @(posedge core_clk);
		n_mismatch++;
		give_verdict();
	end
endmodule // tb_mcu_move_logic_mul_instr

bind mml_exec mml_exec_monitor mon_u (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .exec_busy(exec_busy));
